// >>> design/pspt_consts.svh
`ifndef PSPT_CONSTS_SVH
`define PSPT_CONSTS_SVH

// ----------------------------------------
// Device register addresses
// ----------------------------------------
`define PSPT_ADDR_DATA 8'h08
`define PSPT_ADDR_CTLPORT 8'h09
`define PSPT_ADDR_IRQF 8'h0c
`define PSPT_ADDR_DDIR 8'h88
`define PSPT_ADDR_STAT 8'h89
`define PSPT_ADDR_IRQE 8'h8c
`define PSPT_ADDR_ANCFG 8'h9f

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define PSPT_ST_IBF 7
`define PSPT_ST_OBF 6
`define PSPT_ST_INPUT_OVERFLOW_FLAG 5
`define PSPT_ST_MODE 4
`define PSPT_IRQ_BIT 7
`define PSPT_STAT_RST 8'h0f
`define PSPT_DDIR_RST 8'hff
`define PSPT_ZERO8 8'h00

// ----------------------------------------
// Host command registers
// ----------------------------------------
`define PSPT_H_CMD 8'h00
`define PSPT_H_STATUS 8'h04
`define PSPT_H_CMD_READ 8

// ----------------------------------------
// Timing
// ----------------------------------------
`define PSPT_CLK_NS 10
`define PSPT_STROBE_NS 100
`define PSPT_HOLD_NS 40
`define PSPT_STROBE_CYC ((`PSPT_STROBE_NS + `PSPT_CLK_NS - 1) / `PSPT_CLK_NS)
`define PSPT_HOLD_CYC ((`PSPT_HOLD_NS + `PSPT_CLK_NS - 1) / `PSPT_CLK_NS)

`endif

// >>> design/pspt_pkg.sv
package pspt_pkg;
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } pspt_phase_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SETUP = 2'b01,
    H_STROBE = 2'b10,
    H_HOLD = 2'b11
  } pspt_hstate_t;
endpackage

// >>> design/pspt_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pspt_if;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic [7:0] host_d_o;
  logic host_d_oe;
  logic [7:0] dev_d_o;
  logic [7:0] dev_d_oe;
  logic [2:0] dev_ctl_o;
  logic [2:0] dev_ctl_oe;
  logic [7:0] data;
  logic [2:0] ctl;

  // Undriven bus floats high, as through pull-ups
  assign data = (dev_d_oe & dev_d_o) |
                (~dev_d_oe & (host_d_oe ? host_d_o : 8'hff));
  assign ctl = (dev_ctl_oe & dev_ctl_o) |
               (~dev_ctl_oe & {cs_n, wr_n, rd_n});

  modport dev (
    input data, ctl,
    output dev_d_o, dev_d_oe, dev_ctl_o, dev_ctl_oe
  );
  modport host (
    input data,
    output cs_n, rd_n, wr_n, host_d_o, host_d_oe
  );
endinterface
`default_nettype wire

// >>> design/pspt_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pspt_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST = '0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= RST;
      sync_ff <= RST;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule
`default_nettype wire

// >>> design/pspt_device.sv
`timescale 1ns/10ps
`default_nettype none
`include "pspt_consts.svh"
module pspt_device (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins
  pspt_if.dev pins,
  // Firmware register port
  input wire logic [7:0] fw_addr,
  input wire logic fw_wr,
  input wire logic fw_rd,
  input wire logic [7:0] fw_wdata,
  output logic [7:0] fw_rdata,
  // Interrupt request
  output logic irq
);
  logic [2:0] ctl_s;
  logic [7:0] d_s;
  pspt_pkg::pspt_phase_t phase_ff;
  logic [7:0] in_latch_ff;
  logic [7:0] out_latch_ff;
  logic [7:0] nxt_out_latch;
  logic [7:0] cap_ff;
  logic [7:0] ddir_ff;
  logic [2:0] cdir_ff;
  logic [2:0] cport_ff;
  logic [7:0] ancfg_ff;
  logic mode_ff;
  logic ibf_ff;
  logic obf_ff;
  logic input_overflow_flag_ff;
  logic irqf_ff;
  logic irqe_ff;
  logic wr_act_ff;
  logic rd_act_ff;
  logic pend_ff;
  logic pend_wr_ff;
  logic q2_seen_ff;
  logic [7:0] rdata_ff;
  logic irq_ff;
  logic [7:0] d_o_ff;
  logic [7:0] d_oe_ff;
  logic [2:0] ctl_o_ff;
  logic [2:0] ctl_oe_ff;
  logic wr_act;
  logic rd_act;
  logic wr_done;
  logic rd_done;
  logic fire;
  logic [7:0] nxt_rdata;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Strobes idle high so reset value avoids a false release
  pspt_sync #(.WIDTH(3), .RST(3'b111)) u_ctl_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(pins.ctl),
    .dout(ctl_s)
  );

  pspt_sync #(.WIDTH(8), .RST(8'h00)) u_dat_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(pins.data),
    .dout(d_s)
  );

  // ----------------------------------------
  // Strobe decode
  // ----------------------------------------
  // Bit 0 read, bit 1 write, bit 2 select, active low
  assign wr_act = mode_ff & ~ctl_s[2] & ~ctl_s[1];
  assign rd_act = mode_ff & ~ctl_s[2] & ~ctl_s[0];
  // Release edge detected on the synchronised strobes
  assign wr_done = mode_ff & wr_act_ff & ~wr_act;
  assign rd_done = mode_ff & rd_act_ff & ~rd_act;
  assign fire = pend_ff & q2_seen_ff & (phase_ff == pspt_pkg::PH_Q4);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_act_ff <= 1'b0;
      rd_act_ff <= 1'b0;
    end else begin
      wr_act_ff <= wr_act;
      rd_act_ff <= rd_act;
    end
  end

  // ----------------------------------------
  // Phase clock and completion timing
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= pspt_pkg::PH_Q1;
    end else begin
      phase_ff <= pspt_pkg::pspt_phase_t'(phase_ff + 2'd1);
    end
  end

  // Flags land on the Q4 after the next Q2
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff <= 1'b0;
      pend_wr_ff <= 1'b0;
      q2_seen_ff <= 1'b0;
    end else if (wr_done || rd_done) begin
      pend_ff <= 1'b1;
      pend_wr_ff <= pend_wr_ff | wr_done;
      q2_seen_ff <= 1'b0;
    end else if (fire) begin
      pend_ff <= 1'b0;
      pend_wr_ff <= 1'b0;
      q2_seen_ff <= 1'b0;
    end else if (pend_ff && phase_ff == pspt_pkg::PH_Q2) begin
      q2_seen_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // Data latches
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_ff <= `PSPT_ZERO8;
      in_latch_ff <= `PSPT_ZERO8;
    end else begin
      if (wr_act) begin
        cap_ff <= d_s;
      end
      if (wr_done) begin
        in_latch_ff <= cap_ff;
      end
    end
  end

  // One address, two latches: writes go out, reads come in
  always_comb begin
    nxt_out_latch = out_latch_ff;
    if (fw_wr && hit(fw_addr, `PSPT_ADDR_DATA)) begin
      nxt_out_latch = fw_wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_latch_ff <= `PSPT_ZERO8;
    end else begin
      out_latch_ff <= nxt_out_latch;
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ibf_ff <= 1'b0;
    end else if (!mode_ff) begin
      ibf_ff <= 1'b0;
    end else if (fire && pend_wr_ff) begin
      ibf_ff <= 1'b1;
    end else if (fw_rd && hit(fw_addr, `PSPT_ADDR_DATA)) begin
      ibf_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      obf_ff <= 1'b0;
    end else if (!mode_ff) begin
      obf_ff <= 1'b0;
    end else if (rd_act) begin
      obf_ff <= 1'b0;
    end else if (fw_wr && hit(fw_addr, `PSPT_ADDR_DATA)) begin
      obf_ff <= 1'b1;
    end
  end

  // Overflow survives mode changes; only firmware clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_overflow_flag_ff <= 1'b0;
    end else if (wr_done && ibf_ff) begin
      input_overflow_flag_ff <= 1'b1;
    end else if (fw_wr && hit(fw_addr, `PSPT_ADDR_STAT)) begin
      input_overflow_flag_ff <= fw_wdata[`PSPT_ST_INPUT_OVERFLOW_FLAG];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irqf_ff <= 1'b0;
    end else if (fire) begin
      irqf_ff <= 1'b1;
    end else if (fw_wr && hit(fw_addr, `PSPT_ADDR_IRQF)) begin
      irqf_ff <= fw_wdata[`PSPT_IRQ_BIT];
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= 1'b0;
      cdir_ff <= 3'(`PSPT_STAT_RST);
      ddir_ff <= `PSPT_DDIR_RST;
      cport_ff <= 3'b000;
      irqe_ff <= 1'b0;
      ancfg_ff <= `PSPT_ZERO8;
    end else if (fw_wr) begin
      if (hit(fw_addr, `PSPT_ADDR_STAT)) begin
        mode_ff <= fw_wdata[`PSPT_ST_MODE];
        cdir_ff <= fw_wdata[2:0];
      end
      if (hit(fw_addr, `PSPT_ADDR_DDIR)) begin
        ddir_ff <= fw_wdata;
      end
      if (hit(fw_addr, `PSPT_ADDR_CTLPORT)) begin
        cport_ff <= fw_wdata[2:0];
      end
      if (hit(fw_addr, `PSPT_ADDR_IRQE)) begin
        irqe_ff <= fw_wdata[`PSPT_IRQ_BIT];
      end
      if (hit(fw_addr, `PSPT_ADDR_ANCFG)) begin
        ancfg_ff <= fw_wdata;
      end
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // In slave mode drive follows the synchronised strobes, so it lags the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_o_ff <= `PSPT_ZERO8;
      d_oe_ff <= `PSPT_ZERO8;
      ctl_o_ff <= 3'b000;
      ctl_oe_ff <= 3'b000;
    end else if (mode_ff) begin
      d_o_ff <= nxt_out_latch;
      d_oe_ff <= {8{rd_act}};
      ctl_o_ff <= cport_ff;
      ctl_oe_ff <= 3'b000;
    end else begin
      d_o_ff <= nxt_out_latch;
      d_oe_ff <= ~ddir_ff;
      ctl_o_ff <= cport_ff;
      ctl_oe_ff <= ~cdir_ff;
    end
  end

  assign pins.dev_d_o = d_o_ff;
  assign pins.dev_d_oe = d_oe_ff;
  assign pins.dev_ctl_o = ctl_o_ff;
  assign pins.dev_ctl_oe = ctl_oe_ff;

  // ----------------------------------------
  // Firmware read port
  // ----------------------------------------
  always_comb begin
    nxt_rdata = `PSPT_ZERO8;
    case (fw_addr)
      `PSPT_ADDR_DATA: begin
        if (mode_ff && !wr_act) begin
          nxt_rdata = in_latch_ff;
        end else begin
          nxt_rdata = d_s;
        end
      end
      `PSPT_ADDR_CTLPORT: nxt_rdata = {5'b00000, ctl_s};
      `PSPT_ADDR_DDIR: nxt_rdata = ddir_ff;
      `PSPT_ADDR_STAT: begin
        // Input-only pin direction always reads one
        nxt_rdata = {ibf_ff, obf_ff, input_overflow_flag_ff, mode_ff, 1'b1,
                     cdir_ff};
      end
      `PSPT_ADDR_IRQF: nxt_rdata = {irqf_ff, 7'b0000000};
      `PSPT_ADDR_IRQE: nxt_rdata = {irqe_ff, 7'b0000000};
      `PSPT_ADDR_ANCFG: nxt_rdata = ancfg_ff;
      default: nxt_rdata = `PSPT_ZERO8;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= `PSPT_ZERO8;
    end else if (fw_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= irqf_ff & irqe_ff;
    end
  end

  assign fw_rdata = rdata_ff;
  assign irq = irq_ff;
endmodule
`default_nettype wire

// >>> design/pspt_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "pspt_consts.svh"
module pspt_host #(
  parameter int STROBE_CYC = `PSPT_STROBE_CYC,
  parameter int HOLD_CYC = `PSPT_HOLD_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  pspt_if.host pins
);
  // Strobe must outlast the far end's synchroniser and capture
  if (STROBE_CYC < 4 || STROBE_CYC > 255 || HOLD_CYC < 3 ||
      HOLD_CYC > 255) begin : g_chk
    $error("pspt_host: strobe or hold count out of range");
  end

  pspt_pkg::pspt_hstate_t state_ff;
  logic [7:0] cnt_ff;
  logic is_read_ff;
  logic [7:0] wdat_ff;
  logic [7:0] rdat_ff;
  logic cs_n_ff;
  logic rd_n_ff;
  logic wr_n_ff;
  logic d_oe_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic start;
  logic mapped;

  assign mapped = (paddr == `PSPT_H_CMD) || (paddr == `PSPT_H_STATUS);
  // Commands while busy are dropped
  assign start = psel & penable & pready_ff & pwrite &
                 (paddr == `PSPT_H_CMD) & (state_ff == pspt_pkg::H_IDLE);

  // ----------------------------------------
  // APB slave, one wait-free access phase
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= psel & ~penable;
      pslverr_ff <= psel & ~penable & ~mapped;
      if (psel && !penable) begin
        prdata_ff <= 32'h0000_0000;
        if (!pwrite && paddr == `PSPT_H_STATUS) begin
          prdata_ff <= {16'h0000, rdat_ff, 7'b0000000,
                        state_ff != pspt_pkg::H_IDLE};
        end
      end
    end
  end

  // ----------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= pspt_pkg::H_IDLE;
      cnt_ff <= 8'h00;
      is_read_ff <= 1'b0;
      wdat_ff <= 8'h00;
      rdat_ff <= 8'h00;
      cs_n_ff <= 1'b1;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
      d_oe_ff <= 1'b0;
    end else begin
      case (state_ff)
        pspt_pkg::H_IDLE: begin
          if (start) begin
            is_read_ff <= pwdata[`PSPT_H_CMD_READ];
            wdat_ff <= pwdata[7:0];
            d_oe_ff <= ~pwdata[`PSPT_H_CMD_READ];
            cs_n_ff <= 1'b0;
            state_ff <= pspt_pkg::H_SETUP;
          end
        end
        pspt_pkg::H_SETUP: begin
          rd_n_ff <= ~is_read_ff;
          wr_n_ff <= is_read_ff;
          cnt_ff <= 8'(STROBE_CYC - 1);
          state_ff <= pspt_pkg::H_STROBE;
        end
        pspt_pkg::H_STROBE: begin
          if (cnt_ff == 8'h00) begin
            if (is_read_ff) begin
              rdat_ff <= pins.data;
            end
            cs_n_ff <= 1'b1;
            rd_n_ff <= 1'b1;
            wr_n_ff <= 1'b1;
            cnt_ff <= 8'(HOLD_CYC - 1);
            state_ff <= pspt_pkg::H_HOLD;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        pspt_pkg::H_HOLD: begin
          // Data held past release so capture sees it stable
          if (cnt_ff == 8'h00) begin
            d_oe_ff <= 1'b0;
            state_ff <= pspt_pkg::H_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        default: state_ff <= pspt_pkg::H_IDLE;
      endcase
    end
  end

  assign pins.cs_n = cs_n_ff;
  assign pins.rd_n = rd_n_ff;
  assign pins.wr_n = wr_n_ff;
  assign pins.host_d_o = wdat_ff;
  assign pins.host_d_oe = d_oe_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
endmodule
`default_nettype wire

// >>> tb/pspt_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module pspt_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Host side
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] host_d_o,
  input wire logic host_d_oe,
  // Device side
  input wire logic [7:0] dev_d_o,
  input wire logic [7:0] dev_d_oe,
  input wire logic [2:0] dev_ctl_o,
  input wire logic [2:0] dev_ctl_oe,
  // Resolved wires
  input wire logic [7:0] data,
  input wire logic [2:0] ctl
);
  // --------------------------------
  // Cycles since the last read strobe
  // --------------------------------
  // Saturates so a long idle never wraps back into the drive window
  logic [3:0] rd_age_ff;
  logic [3:0] nxt_rd_age;
  assign nxt_rd_age = (!cs_n && !rd_n) ? 4'h0 :
                      (rd_age_ff == 4'hf) ? 4'hf : rd_age_ff + 4'h1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_age_ff <= 4'hf;
    end else begin
      rd_age_ff <= nxt_rd_age;
    end
  end

  // --------------------------------
  // Properties
  // --------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  drive_needs_read_a: assert property ((|dev_d_oe) |-> rd_age_ff <= 4'h6)
    else $error("data pins driven without a read");
  read_drives_a: assert property ((!cs_n && !rd_n) [*6] |-> (&dev_d_oe))
    else $error("read strobe not answered by drive");
  release_stops_a: assert property ((rd_age_ff > 4'h7) |-> dev_d_oe == 8'h00)
    else $error("drive kept after read release");
  sync_delay_a: assert property ($rose(|dev_d_oe) |-> $past(!cs_n && !rd_n, 2))
    else $error("drive began before strobe sync");
  whole_byte_a: assert property ((|dev_d_oe) |-> (&dev_d_oe))
    else $error("partial byte driven");
  no_clash_a: assert property (!(host_d_oe && (|dev_d_oe)))
    else $error("both ends drive the data bus");
  write_hold_a: assert property ((!cs_n && !wr_n) |=> (host_d_oe && $stable(host_d_o)))
    else $error("write data not held");
  strobe_width_a: assert property ($fell(wr_n) |-> !wr_n [*4])
    else $error("write strobe too short");
  one_strobe_a: assert property (!(!rd_n && !wr_n))
    else $error("read and write strobes together");
  ctl_input_a: assert property ((!cs_n) |-> dev_ctl_oe == 3'b000)
    else $error("control pins driven while selected");

  cover property ($rose(|dev_d_oe));
  cover property ($fell(wr_n));
endmodule
`default_nettype wire

// >>> tb/tb_parallel_slave_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "pspt_consts.svh"
module tb_parallel_slave_port;
  // --------------------------------
  // Signals and model state
  // --------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] fw_addr = 8'h00;
  logic fw_wr = 1'b0;
  logic fw_rd = 1'b0;
  logic [7:0] fw_wdata = 8'h00;
  logic [7:0] fw_rdata;
  logic irq;
  logic [7:0] host_rd;
  int num_errors = 0;
  int compares = 0;
  int seed = 28679;
  int m_in = 0, m_out = 0, m_ibf = 0, m_obf = 0, m_ov = 0;
  int m_mode = 0, m_dir = 7, m_if = 0, m_ie = 0;

  always #5 pclk = ~pclk;

  // --------------------------------
  // Both ends and the checker
  // --------------------------------
  pspt_if u_pspt_if();
  pspt_device u_pspt_device(.pclk(pclk), .presetn(presetn),
    .pins(u_pspt_if), .fw_addr(fw_addr), .fw_wr(fw_wr), .fw_rd(fw_rd),
    .fw_wdata(fw_wdata), .fw_rdata(fw_rdata), .irq(irq));
  // Short strobe keeps the run brief; strobe above its minimum, hold at its minimum
  pspt_host #(.STROBE_CYC(6), .HOLD_CYC(3)) u_pspt_host(.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(u_pspt_if));
  pspt_asserts u_pspt_asserts(.pclk(pclk), .presetn(presetn),
    .cs_n(u_pspt_if.cs_n), .rd_n(u_pspt_if.rd_n), .wr_n(u_pspt_if.wr_n),
    .host_d_o(u_pspt_if.host_d_o), .host_d_oe(u_pspt_if.host_d_oe),
    .dev_d_o(u_pspt_if.dev_d_o), .dev_d_oe(u_pspt_if.dev_d_oe),
    .dev_ctl_o(u_pspt_if.dev_ctl_o), .dev_ctl_oe(u_pspt_if.dev_ctl_oe),
    .data(u_pspt_if.data), .ctl(u_pspt_if.ctl));

  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic check(input string n, input logic [7:0] e,
      input logic [7:0] g);
    compares++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask

  task automatic conclude();
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic fw_wr_t(input logic [7:0] a, input logic [7:0] v);
    @(posedge pclk);
    fw_addr <= a;
    fw_wdata <= v;
    fw_wr <= 1'b1;
    @(posedge pclk);
    fw_wr <= 1'b0;
  endtask

  task automatic fw_rd_t(input logic [7:0] a, output logic [7:0] v);
    @(posedge pclk);
    fw_addr <= a;
    fw_rd <= 1'b1;
    @(posedge pclk);
    fw_rd <= 1'b0;
    @(posedge pclk);
    #1;
    v = fw_rdata;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic host_cmd(input logic [31:0] c);
    logic [31:0] r;
    logic e;
    int n;
    apb(1'b1, `PSPT_H_CMD, c, r, e);
    n = 0;
    r = 32'h0000_0001;
    while (r[0] !== 1'b0 && n < 40) begin
      apb(1'b0, `PSPT_H_STATUS, 32'h0000_0000, r, e);
      n++;
    end
    if (n >= 40) num_errors++;
    host_rd = r[15:8];
    // Flags land within a few cycles of the sync'd release
    repeat (16) @(posedge pclk);
  endtask

  task automatic hwrite(input logic [7:0] d);
    host_cmd({24'h00_0000, d});
    if (m_mode != 0) begin
      m_ov = m_ov | m_ibf;
      m_ibf = 1;
      m_if = 1;
      m_in = d;
    end
  endtask

  task automatic hread();
    host_cmd(32'h0000_0100);
    check("out_latch", m_out[7:0], host_rd);
    m_obf = 0;
    m_if = 1;
  endtask

  task automatic fw_stat(input logic [7:0] v);
    fw_wr_t(`PSPT_ADDR_STAT, v);
    m_ov = v[5];
    m_mode = v[4];
    m_dir = v[2:0];
    if (m_mode == 0) begin
      m_ibf = 0;
      m_obf = 0;
    end
  endtask

  task automatic fw_data(input logic [7:0] v);
    fw_wr_t(`PSPT_ADDR_DATA, v);
    m_out = v;
    if (m_mode != 0) m_obf = 1;
  endtask

  task automatic fw_get();
    logic [7:0] d;
    fw_rd_t(`PSPT_ADDR_DATA, d);
    check("in_latch", m_in[7:0], d);
    if (m_mode != 0) m_ibf = 0;
  endtask

  task automatic cmp_state();
    logic [7:0] d;
    fw_rd_t(`PSPT_ADDR_STAT, d);
    check("status", {m_ibf[0], m_obf[0], m_ov[0], m_mode[0], 1'b1,
      m_dir[2:0]}, d);
    fw_rd_t(`PSPT_ADDR_IRQF, d);
    check("irq_flag", {m_if[0], 7'h00}, d);
    check("irq", {7'h00, m_if[0] & m_ie[0]}, {7'h00, irq});
  endtask

  // --------------------------------
  // Watchdog
  // --------------------------------
  initial begin
    #300000;
    num_errors++;
    conclude();
  end

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    logic [7:0] d;
    logic [7:0] v;
    logic [31:0] r;
    logic e;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    cmp_state();
    fw_rd_t(`PSPT_ADDR_DDIR, d);
    check("data_dir", 8'hff, d);
    fw_rd_t(8'h55, d);
    check("unmapped", 8'h00, d);
    apb(1'b0, 8'h08, 32'h0000_0000, r, e);
    check("pslverr", 8'h01, {7'h00, e});
    // Plain I/O mode: link traffic ignored, full flags held clear
    hwrite(8'($random(seed)));
    fw_data(8'($random(seed)));
    cmp_state();
    fw_stat(8'h00);
    repeat (2) @(posedge pclk);
    check("ctl_oe", 8'h07, {5'h00, u_pspt_if.dev_ctl_oe});
    cmp_state();
    // Slave mode, interrupt enabled
    fw_wr_t(`PSPT_ADDR_ANCFG, 8'h0f);
    // Pins back to inputs first, else driven-low pins fake a transfer
    fw_stat(8'h07);
    repeat (4) @(posedge pclk);
    fw_stat(8'h17);
    fw_wr_t(`PSPT_ADDR_IRQE, 8'h80);
    m_ie = 1;
    hwrite(8'($random(seed)));
    cmp_state();
    fw_get();
    cmp_state();
    // Firmware reads the live pins in mid-write
    v = 8'($random(seed));
    fork
      hwrite(v);
      begin
        repeat (7) @(posedge pclk);
        fw_rd_t(`PSPT_ADDR_DATA, d);
        check("live_pins", v, d);
      end
    join
    hwrite(8'($random(seed)));
    hwrite(8'($random(seed)));
    cmp_state();
    fw_get();
    fw_stat(8'h17);
    cmp_state();
    fw_wr_t(`PSPT_ADDR_IRQF, 8'h00);
    m_if = 0;
    cmp_state();
    // Reads from the far end, back to back
    fw_data(8'($random(seed)));
    cmp_state();
    hread();
    cmp_state();
    hread();
    cmp_state();
    // Firmware write in mid-read reaches the pins, full stays clear
    fork
      hread();
      begin
        repeat (6) @(posedge pclk);
        fw_data(8'($random(seed)));
      end
    join
    cmp_state();
    fw_wr_t(`PSPT_ADDR_IRQE, 8'h00);
    m_ie = 0;
    cmp_state();
    // Leaving slave mode keeps the overflow
    hwrite(8'($random(seed)));
    hwrite(8'($random(seed)));
    fw_stat(8'h27);
    cmp_state();
    conclude();
  end
endmodule
`default_nettype wire
